// ---- core/fan_diode_voltage_alarm_status.sv ----
// fan, remote diode and supply alarm status with voltage limits
`timescale 1ns/1ps
`default_nettype none
// Operation
// - fan flag sets when count reading exceeds its 16-bit minimum limit
// - bits 6 and 7 flag open or short on diode one and two
// - second status register ignores host writes
// - host read clears flags whose cause is gone; reset reads zero
// - set flags hold until read or enable cleared
// - diode fault flag survives a read while the fault persists
// - running diode fault loads 80h reading and sets limit error
// - clearing diode enable clears its fault and limit error flags
// - no flag rises while its enable is zero
// - enable cleared while set: flag clears at next reading update
// - readings update only while start is one
// - supply error when reading above high or at or below low limit
// - supply readings scaled so nominal voltage gives C0h
// - cpu rail 2.25 V to C0h, main supply 3.3 V to C0h, clamp FFh
// - voltage limits always writable; low resets 00h, high FFh
// - start at zero: no monitoring and no flags set
// - summary bit 7 of first status shows any second status bit
module fan_diode_voltage_alarm_status (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [fan_alarm_pkg::num_fans-1:0][15:0] fan_count,
  input wire logic [fan_alarm_pkg::num_fans-1:0][15:0] fan_min_limit,
  input wire logic [fan_alarm_pkg::num_fans-1:0] fan_count_update,
  input wire logic [fan_alarm_pkg::num_fans-1:0] fan_irq_en,
  input wire logic remote_one_open_short,
  input wire logic remote_two_open_short,
  input wire logic [fan_alarm_pkg::num_diodes-1:0][7:0] remote_temp,
  input wire logic [fan_alarm_pkg::num_diodes-1:0] remote_conv_done,
  input wire logic [fan_alarm_pkg::num_diodes-1:0] remote_limit_hit,
  input wire logic [fan_alarm_pkg::num_diodes-1:0] remote_irq_en,
  input wire logic [fan_alarm_pkg::mv_w-1:0] cpu_rail_mv,
  input wire logic [fan_alarm_pkg::mv_w-1:0] main_supply_mv,
  input wire logic volt_conv_done,
  input wire logic [fan_alarm_pkg::num_rails-1:0] volt_irq_en,
  output logic [7:0] fan_diode_alarm_status,
  output logic [7:0] first_status,
  output logic second_status_summary,
  output logic remote_sensor_one_fault,
  output logic remote_sensor_two_fault,
  output logic remote_one_limit_error,
  output logic remote_two_limit_error,
  output logic [7:0] cpu_rail_reading,
  output logic [7:0] main_supply_reading,
  output logic [7:0] remote_one_reading,
  output logic [7:0] remote_two_reading
);
  import fan_alarm_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic rd1;
  logic rd2;
  logic [num_fans-1:0] fan_upd;
  logic [num_fans-1:0] fan_slow;
  logic [num_fans-1:0] fan_flag;
  logic [num_diodes-1:0] fault_meta_r;
  logic [num_diodes-1:0] fault_r;
  logic [num_diodes-1:0] dio_upd;
  logic [num_diodes-1:0] dio_fault;
  logic [num_diodes-1:0] dio_lim;
  logic [num_diodes-1:0] lim_hit_r;
  logic [num_diodes-1:0] lim_new;
  logic [num_diodes-1:0] lim_now;
  logic [num_diodes-1:0][7:0] dio_read_r;
  logic [num_rails-1:0][7:0] volt_lo_r;
  logic [num_rails-1:0][7:0] volt_hi_r;
  logic [num_rails-1:0][7:0] volt_read_r;
  logic [num_rails-1:0][7:0] volt_nxt;
  logic [num_rails-1:0] volt_bad_new;
  logic [num_rails-1:0] volt_bad_now;
  logic [num_rails-1:0] volt_flag;
  logic volt_upd;
  logic summary_r;
  logic [7:0] status2_v;
  logic [7:0] status1_v;
  logic [7:0] rdata_r;
  logic rvalid_r;

  // ********************************
  // supply scaling
  // ********************************
  function automatic logic [7:0] scale_mv(input logic [mv_w-1:0] mv,
                                          input logic [31:0] nom);
    logic [31:0] q;
    q = (({19'h0_0000, mv} * nominal_code) + (nom >> 1)) / nom;
    scale_mv = (q > full_code) ? full_code[7:0] : q[7:0];
  endfunction : scale_mv

  assign volt_nxt[0] = scale_mv(cpu_rail_mv, cpu_nom_mv);
  assign volt_nxt[1] = scale_mv(main_supply_mv, main_nom_mv);

  // ********************************
  // register access decode
  // ********************************
  assign rd1 = reg_rd && (reg_addr == status1_addr);
  assign rd2 = reg_rd && (reg_addr == status2_addr);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      volt_lo_r <= {num_rails{low_limit_rst}};
      volt_hi_r <= {num_rails{high_limit_rst}};
    end else if (ce && reg_wr) begin
      // no lock gating here on purpose
      if (reg_addr == cpu_lo_addr) begin
        volt_lo_r[0] <= reg_wdata;
      end
      if (reg_addr == cpu_hi_addr) begin
        volt_hi_r[0] <= reg_wdata;
      end
      if (reg_addr == main_lo_addr) begin
        volt_lo_r[1] <= reg_wdata;
      end
      if (reg_addr == main_hi_addr) begin
        volt_hi_r[1] <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else if (ce) begin
      rvalid_r <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          status1_addr: rdata_r <= status1_v;
          status2_addr: rdata_r <= status2_v;
          cpu_lo_addr: rdata_r <= volt_lo_r[0];
          cpu_hi_addr: rdata_r <= volt_hi_r[0];
          main_lo_addr: rdata_r <= volt_lo_r[1];
          main_hi_addr: rdata_r <= volt_hi_r[1];
          default: rdata_r <= 8'h00;
        endcase
      end
    end
  end

  // ********************************
  // fan speed flags
  // ********************************
  for (genvar i = 0; i < num_fans; i++) begin : g_fan
    assign fan_upd[i] = start && fan_count_update[i];
    assign fan_slow[i] = fan_count[i] > fan_min_limit[i];
    sticky_alarm_flag u_flag (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .update(fan_upd[i]),
      .en(fan_irq_en[i]),
      .cond_new(fan_slow[i]),
      .cond_now(fan_slow[i]),
      .rd_clr(rd2),
      .flag(fan_flag[i])
    );

    property p_fan_set;
      ce && fan_upd[i] && fan_irq_en[i] && fan_slow[i] |=> fan_flag[i];
    endproperty
    a_fan_set: assert property (p_fan_set)
      else $error("fan flag missed a slow reading");

    property p_fan_hold;
      fan_flag[i] && !rd2 && !(fan_upd[i] && !fan_irq_en[i])
        |=> fan_flag[i];
    endproperty
    a_fan_hold: assert property (p_fan_hold)
      else $error("fan flag dropped without read or disable");

    property p_fan_rdclr;
      ce && rd2 && !fan_slow[i] && !fan_upd[i] |=> !fan_flag[i];
    endproperty
    a_fan_rdclr: assert property (p_fan_rdclr)
      else $error("fan flag not cleared by read");

    property p_fan_quiet;
      !fan_flag[i] && !fan_irq_en[i] |=> !fan_flag[i];
    endproperty
    a_fan_quiet: assert property (p_fan_quiet)
      else $error("fan flag rose while disabled");

    property p_fan_nostart;
      !fan_flag[i] && !start |=> !fan_flag[i];
    endproperty
    a_fan_nostart: assert property (p_fan_nostart)
      else $error("fan flag rose while stopped");
  end

  // ********************************
  // remote diode faults and readings
  // ********************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_meta_r <= '0;
      fault_r <= '0;
    end else if (ce) begin
      fault_meta_r <= {remote_two_open_short, remote_one_open_short};
      fault_r <= fault_meta_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dio_read_r <= {num_diodes{reading_rst}};
      lim_hit_r <= '0;
    end else if (ce) begin
      for (int k = 0; k < num_diodes; k++) begin
        if (dio_upd[k]) begin
          dio_read_r[k] <= fault_r[k] ? diode_fault_code
                                      : remote_temp[k];
          lim_hit_r[k] <= remote_limit_hit[k];
        end
      end
    end
  end

  for (genvar d = 0; d < num_diodes; d++) begin : g_dio
    assign dio_upd[d] = start && remote_conv_done[d];
    // forced fault code counts as a limit violation
    assign lim_new[d] = fault_r[d] || remote_limit_hit[d];
    assign lim_now[d] = fault_r[d] || lim_hit_r[d];
    sticky_alarm_flag u_fault (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .update(dio_upd[d]),
      .en(remote_irq_en[d]),
      .cond_new(fault_r[d]),
      .cond_now(fault_r[d]),
      .rd_clr(rd2),
      .flag(dio_fault[d])
    );
    sticky_alarm_flag u_lim (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .update(dio_upd[d]),
      .en(remote_irq_en[d]),
      .cond_new(lim_new[d]),
      .cond_now(lim_now[d]),
      .rd_clr(rd1),
      .flag(dio_lim[d])
    );

    sequence s_fault_conv;
      ce && dio_upd[d] && fault_r[d];
    endsequence
    sequence s_fault_seen;
      dio_read_r[d] == diode_fault_code;
    endsequence
    property p_fault_code;
      s_fault_conv |=> s_fault_seen;
    endproperty
    a_fault_code: assert property (p_fault_code)
      else $error("diode fault did not load fault code");

    property p_fault_flags;
      s_fault_conv ##0 remote_irq_en[d] |=> dio_fault[d] && dio_lim[d];
    endproperty
    a_fault_flags: assert property (p_fault_flags)
      else $error("diode fault flags not both set");

    property p_fault_keep;
      dio_fault[d] && fault_r[d] && !(dio_upd[d] && !remote_irq_en[d])
        |=> dio_fault[d];
    endproperty
    a_fault_keep: assert property (p_fault_keep)
      else $error("diode fault flag cleared while fault present");

    property p_dis_clear;
      ce && dio_upd[d] && !remote_irq_en[d] |=> !dio_fault[d] && !dio_lim[d];
    endproperty
    a_dis_clear: assert property (p_dis_clear)
      else $error("disabled diode flags not cleared");

    property p_read_frozen;
      !start |=> $stable(dio_read_r[d]);
    endproperty
    a_read_frozen: assert property (p_read_frozen)
      else $error("diode reading moved while stopped");
  end

  // ********************************
  // supply readings and errors
  // ********************************
  assign volt_upd = start && volt_conv_done;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      volt_read_r <= {num_rails{reading_rst}};
    end else if (ce && volt_upd) begin
      volt_read_r <= volt_nxt;
    end
  end

  for (genvar r = 0; r < num_rails; r++) begin : g_rail
    assign volt_bad_new[r] = (volt_nxt[r] > volt_hi_r[r]) ||
                             (volt_nxt[r] <= volt_lo_r[r]);
    assign volt_bad_now[r] = (volt_read_r[r] > volt_hi_r[r]) ||
                             (volt_read_r[r] <= volt_lo_r[r]);
    sticky_alarm_flag u_volt (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .update(volt_upd),
      .en(volt_irq_en[r]),
      .cond_new(volt_bad_new[r]),
      .cond_now(volt_bad_now[r]),
      .rd_clr(rd1),
      .flag(volt_flag[r])
    );

    property p_volt_set;
      ce && volt_upd && volt_irq_en[r] &&
        (volt_nxt[r] <= volt_lo_r[r]) |=> volt_flag[r];
    endproperty
    a_volt_set: assert property (p_volt_set)
      else $error("supply error missed low limit");

    property p_volt_off;
      ce && volt_upd && !volt_irq_en[r] |=> !volt_flag[r];
    endproperty
    a_volt_off: assert property (p_volt_off)
      else $error("disabled supply flag not cleared on update");
  end

  // ********************************
  // status assembly and summary
  // ********************************
  always_comb begin
    status2_v = status_rst;
    status2_v[fan_bit_lo +: num_fans] = fan_flag;
    status2_v[diode_one_bit] = dio_fault[0];
    status2_v[diode_two_bit] = dio_fault[1];
  end

  always_comb begin
    status1_v = status_rst;
    status1_v[cpu_err_bit] = volt_flag[0];
    status1_v[main_err_bit] = volt_flag[1];
    status1_v[lim_one_bit] = dio_lim[0];
    status1_v[lim_two_bit] = dio_lim[1];
    status1_v[summary_bit] = summary_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      summary_r <= 1'b0;
    end else if (ce) begin
      summary_r <= |status2_v;
    end
  end

  property p_summary;
    $past(ce) |-> summary_r == $past(|status2_v);
  endproperty
  a_summary: assert property (p_summary)
    else $error("summary bit does not follow second status");

  property p_no_write;
    ce && reg_wr && reg_addr == status2_addr && !reg_rd &&
      !(|fan_upd) && !(|dio_upd) |=> $stable(status2_v);
  endproperty
  a_no_write: assert property (p_no_write)
    else $error("write changed second status");

  property p_reserved;
    status2_v[1:0] == 2'b00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved status bits set");

  property p_scale;
    ce && volt_upd && {19'h0_0000, cpu_rail_mv} == cpu_nom_mv
      |=> volt_read_r[0] == nominal_code[7:0];
  endproperty
  a_scale: assert property (p_scale)
    else $error("cpu rail nominal did not read C0h");

  property p_limit_wr;
    ce && reg_wr && reg_addr == cpu_lo_addr |=>
      volt_lo_r[0] == $past(reg_wdata);
  endproperty
  a_limit_wr: assert property (p_limit_wr)
    else $error("cpu low limit write lost");

  // ********************************
  // outputs
  // ********************************
  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign fan_diode_alarm_status = status2_v;
  assign first_status = status1_v;
  assign second_status_summary = summary_r;
  assign remote_sensor_one_fault = dio_fault[0];
  assign remote_sensor_two_fault = dio_fault[1];
  assign remote_one_limit_error = dio_lim[0];
  assign remote_two_limit_error = dio_lim[1];
  assign cpu_rail_reading = volt_read_r[0];
  assign main_supply_reading = volt_read_r[1];
  assign remote_one_reading = dio_read_r[0];
  assign remote_two_reading = dio_read_r[1];
endmodule : fan_diode_voltage_alarm_status
`default_nettype wire

// ---- core/fan_alarm_pkg.sv ----
// shared constants for the fan, diode and supply alarm block
`default_nettype none
package fan_alarm_pkg;
  localparam int num_fans = 4;
  localparam int num_diodes = 2;
  localparam int num_rails = 2;
  localparam int mv_w = 13;
  // ********************************
  // register offsets
  // ********************************
  localparam logic [7:0] status1_addr = 8'h41;
  localparam logic [7:0] status2_addr = 8'h42;
  localparam logic [7:0] cpu_lo_addr = 8'h46;
  localparam logic [7:0] cpu_hi_addr = 8'h47;
  localparam logic [7:0] main_lo_addr = 8'h48;
  localparam logic [7:0] main_hi_addr = 8'h49;
  // ********************************
  // field positions
  // ********************************
  localparam int fan_bit_lo = 2;
  localparam int diode_one_bit = 6;
  localparam int diode_two_bit = 7;
  localparam int cpu_err_bit = 1;
  localparam int main_err_bit = 2;
  localparam int lim_one_bit = 4;
  localparam int lim_two_bit = 6;
  localparam int summary_bit = 7;
  // ********************************
  // reset values and codes
  // ********************************
  localparam logic [7:0] status_rst = 8'h00;
  localparam logic [7:0] low_limit_rst = 8'h00;
  localparam logic [7:0] high_limit_rst = 8'hff;
  localparam logic [7:0] reading_rst = 8'h00;
  localparam logic [7:0] diode_fault_code = 8'h80;
  // ********************************
  // supply scaling, nominal in millivolts
  // ********************************
  localparam logic [31:0] cpu_nom_mv = 32'h0000_08ca;
  localparam logic [31:0] main_nom_mv = 32'h0000_0ce4;
  localparam logic [31:0] nominal_code = 32'h0000_00c0;
  localparam logic [31:0] full_code = 32'h0000_00ff;
endpackage : fan_alarm_pkg
`default_nettype wire

// ---- core/sticky_alarm_flag.sv ----
// one sticky alarm flag with enable, update and read clear
`timescale 1ns/1ps
`default_nettype none
module sticky_alarm_flag (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic update,
  input wire logic en,
  input wire logic cond_new,
  input wire logic cond_now,
  input wire logic rd_clr,
  output logic flag
);
  import fan_alarm_pkg::*;

  // set beats both clears; disabled flag drops at next update
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (ce) begin
      if (update && en && cond_new) begin
        flag <= 1'b1;
      end else if (update && !en) begin
        flag <= 1'b0;
      end else if (rd_clr && !cond_now) begin
        flag <= 1'b0;
      end
    end
  end
endmodule : sticky_alarm_flag
`default_nettype wire

// ---- dv/host_access_model.sv ----
// host model driving the block's register strobe interface
`timescale 1ns/1ps
`default_nettype none
module host_access_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    // idle lines stop showing the last value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    ok = reg_rvalid;
  endtask : rd
endmodule : host_access_model
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for the fan, diode and supply alarm block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fan_alarm_pkg::*;
  typedef struct {
    logic [12:0] cmv, mmv;
    logic [7:0] clo, chi, mlo, mhi, crd, mrd;
    logic [1:0] err;
  } vcase_s;
  logic clk, rst_n, ce_in, start, reg_wr, reg_rd, reg_rvalid, summ, volt_done;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, st1, st2, cpu_rd, main_rd;
  logic [num_fans-1:0][15:0] fan_count, fan_min;
  logic [num_fans-1:0] fan_upd, fan_en;
  logic [1:0] diode_fault, conv_done, limit_hit, diode_en, volt_en;
  logic [1:0] f_flag, l_flag;
  logic [1:0][7:0] remote_temp, remote_rd;
  logic [12:0] cpu_mv, main_mv;
  logic [7:0] exp;
  int n_fail = 0;
  int n_compared = 0;
  logic [7:0] lim_a [4];
  logic [7:0] lim_rst [4] = '{8'h00, 8'hff, 8'h00, 8'hff};
  vcase_s vt [5] = '{
    '{13'h08ca, 13'h0ce4, 8'h00, 8'hff, 8'h00, 8'hff, 8'hc0, 8'hc0, 2'h0},
    '{13'h0bb8, 13'h111c, 8'h00, 8'hff, 8'h00, 8'hff, 8'hff, 8'hff, 2'h0},
    '{13'h0000, 13'h0000, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'h00, 2'h3},
    '{13'h08ca, 13'h0ce4, 8'hc0, 8'hff, 8'h00, 8'hbf, 8'hc0, 8'hc0, 2'h3},
    '{13'h08ca, 13'h0ce4, 8'hbf, 8'hc0, 8'hbf, 8'hc0, 8'hc0, 8'hc0, 2'h0}};

  fan_diode_voltage_alarm_status fan_diode_voltage_alarm_status_i (
    .clk(clk), .rst_n(rst_n), .ce(ce_in), .start(start),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .fan_count(fan_count), .fan_min_limit(fan_min),
    .fan_count_update(fan_upd), .fan_irq_en(fan_en),
    .remote_one_open_short(diode_fault[0]),
    .remote_two_open_short(diode_fault[1]),
    .remote_temp(remote_temp), .remote_conv_done(conv_done),
    .remote_limit_hit(limit_hit), .remote_irq_en(diode_en),
    .cpu_rail_mv(cpu_mv), .main_supply_mv(main_mv),
    .volt_conv_done(volt_done), .volt_irq_en(volt_en),
    .fan_diode_alarm_status(st2), .first_status(st1),
    .second_status_summary(summ),
    .remote_sensor_one_fault(f_flag[0]), .remote_sensor_two_fault(f_flag[1]),
    .remote_one_limit_error(l_flag[0]), .remote_two_limit_error(l_flag[1]),
    .cpu_rail_reading(cpu_rd), .main_supply_reading(main_rd),
    .remote_one_reading(remote_rd[0]), .remote_two_reading(remote_rd[1]));

  host_access_model host_access_model_i (
    .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // ********************************
  // helpers
  // ********************************
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] got);
    n_compared++;
    if (got !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask : tick

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e,
                       input string nm);
    logic [7:0] d;
    logic ok;
    host_access_model_i.rd(a, d, ok);
    chk({nm, " valid"}, 16'h0001, {15'h0000, ok});
    chk(nm, {8'h00, e}, {8'h00, d});
  endtask : rdchk

  // kind 0 fan, 1 diode, else supply
  task automatic upd(input int kind, input int idx);
    case (kind)
      0: fan_upd[idx] = 1'b1;
      1: conv_done[idx] = 1'b1;
      default: volt_done = 1'b1;
    endcase
    tick(1);
    fan_upd = '0;
    conv_done = '0;
    volt_done = 1'b0;
    tick(1);
  endtask : upd

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("MISMATCH watchdog expected done seen timeout");
    end_of_test();
  end

  // ********************************
  // tests
  // ********************************
  initial begin
    lim_a = '{cpu_lo_addr, cpu_hi_addr, main_lo_addr, main_hi_addr};
    rst_n = 1'b0;
    ce_in = 1'b1;
    start = 1'b0;
    fan_count = '0;
    fan_min = '0;
    fan_upd = '0;
    fan_en = '0;
    diode_fault = '0;
    conv_done = '0;
    limit_hit = '0;
    diode_en = '0;
    remote_temp = '0;
    cpu_mv = 13'h0000;
    main_mv = 13'h0000;
    volt_done = 1'b0;
    volt_en = 2'b00;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk("status2 reset", 16'h0000, {8'h00, st2});
    rdchk(status2_addr, 8'h00, "status2 reset read");
    rdchk(8'h60, 8'h00, "unmapped");
    for (int i = 0; i < 4; i++) begin
      rdchk(lim_a[i], lim_rst[i], "limit reset");
      host_access_model_i.wr(lim_a[i], 8'h5a ^ lim_a[i]);
      rdchk(lim_a[i], 8'h5a ^ lim_a[i], "limit write");
    end
    host_access_model_i.wr(status2_addr, 8'hff);
    rdchk(status2_addr, 8'h00, "status2 write");
    // clock enable low must swallow the write
    ce_in = 1'b0;
    host_access_model_i.wr(cpu_lo_addr, 8'h33);
    ce_in = 1'b1;
    rdchk(cpu_lo_addr, 8'h5a ^ cpu_lo_addr, "frozen write");
    $display("test registers done");

    start = 1'b1;
    fan_en = 4'hf;
    for (int i = 0; i < 4; i++) begin
      exp = 8'h04 << i;
      fan_min[i] = 16'h1234;
      fan_count[i] = 16'h1234;
      upd(0, i);
      chk("fan at limit", 16'h0000, {8'h00, st2});
      fan_count[i] = 16'h1235;
      upd(0, i);
      chk("fan slow", {8'h00, exp}, {8'h00, st2});
      chk("summary", 16'h0001, {15'h0000, summ});
      chk("first summary", 16'h0001, {15'h0000, st1[7]});
      host_access_model_i.wr(status2_addr, 8'h00);
      chk("write ignored", {8'h00, exp}, {8'h00, st2});
      rdchk(status2_addr, exp, "status2 live");
      chk("kept while slow", {8'h00, exp}, {8'h00, st2});
      fan_count[i] = 16'h0100;
      upd(0, i);
      chk("sticky", {8'h00, exp}, {8'h00, st2});
      rdchk(status2_addr, exp, "status2 read");
      chk("read cleared", 16'h0000, {8'h00, st2});
      tick(1);
      chk("summary clear", 16'h0000, {15'h0000, summ});
    end
    fan_en[0] = 1'b0;
    fan_count[0] = 16'hffff;
    upd(0, 0);
    chk("disabled no set", 16'h0000, {8'h00, st2});
    fan_en[0] = 1'b1;
    upd(0, 0);
    start = 1'b0;
    fan_en[0] = 1'b0;
    upd(0, 0);
    chk("held start off", 16'h0004, {8'h00, st2});
    start = 1'b1;
    upd(0, 0);
    chk("enable clear", 16'h0000, {8'h00, st2});
    $display("test fans done");

    diode_en = 2'b11;
    for (int d = 0; d < 2; d++) begin
      exp = d ? 8'h80 : 8'h40;
      diode_fault[d] = 1'b1;
      tick(3);
      remote_temp[d] = 8'h19;
      upd(1, d);
      chk("fault reading", 16'h0080, {8'h00, remote_rd[d]});
      chk("fault bit", {8'h00, exp}, {8'h00, st2});
      chk("limit error", 16'h0001, {15'h0000, l_flag[d]});
      rdchk(status1_addr, d ? 8'hc0 : 8'h90, "status1 fault");
      rdchk(status2_addr, exp, "fault read");
      chk("fault kept", {8'h00, exp}, {8'h00, st2});
      diode_en[d] = 1'b0;
      upd(1, d);
      chk("fault off", 16'h0000, {8'h00, st2});
      chk("limit off", 16'h0000, {14'h0000, l_flag});
      diode_en[d] = 1'b1;
      diode_fault[d] = 1'b0;
      tick(3);
      upd(1, d);
      chk("diode reading", 16'h0019, {8'h00, remote_rd[d]});
      chk("no fault", 16'h0000, {14'h0000, f_flag});
      limit_hit[d] = 1'b1;
      upd(1, d);
      limit_hit[d] = 1'b0;
      upd(1, d);
      chk("limit hit", 16'h0001, {15'h0000, l_flag[d]});
      rdchk(status1_addr, d ? 8'h40 : 8'h10, "status1 limit");
      chk("limit read", 16'h0000, {14'h0000, l_flag});
    end
    $display("test diodes done");

    for (int i = 0; i < 5; i++) begin
      host_access_model_i.wr(cpu_lo_addr, vt[i].clo);
      host_access_model_i.wr(cpu_hi_addr, vt[i].chi);
      host_access_model_i.wr(main_lo_addr, vt[i].mlo);
      host_access_model_i.wr(main_hi_addr, vt[i].mhi);
      cpu_mv = vt[i].cmv;
      main_mv = vt[i].mmv;
      volt_en = 2'b00;
      upd(2, 0);
      volt_en = 2'b11;
      upd(2, 0);
      chk("cpu reading", {8'h00, vt[i].crd}, {8'h00, cpu_rd});
      chk("main reading", {8'h00, vt[i].mrd}, {8'h00, main_rd});
      chk("supply errors", 16'(vt[i].err), 16'(st1[2:1]));
    end
    start = 1'b0;
    cpu_mv = 13'h0000;
    upd(2, 0);
    chk("cpu frozen", 16'h00c0, {8'h00, cpu_rd});
    chk("no error stopped", 16'h0000, {14'h0000, st1[2:1]});
    start = 1'b1;
    upd(2, 0);
    chk("cpu low error", 16'h0001, 16'(st1[2:1]));
    cpu_mv = 13'h08ca;
    upd(2, 0);
    chk("supply sticky", 16'h0001, 16'(st1[2:1]));
    rdchk(status1_addr, 8'h02, "status1 read");
    chk("status1 cleared", 16'h0000, 16'(st1[2:1]));
    // reset again in mid-run: cpu limits must return to defaults
    rst_n = 1'b0;
    tick(1);
    rst_n = 1'b1;
    rdchk(cpu_lo_addr, low_limit_rst, "low limit rerun");
    rdchk(cpu_hi_addr, high_limit_rst, "high limit rerun");
    $display("test supplies done");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
